// ### logic/ulpi_register_access_port.v
// device end of the ulpi synchronous port: direction, command decode, register access
`timescale 1ns/1ps
`include "ulpi_port_consts.vh"

module ulpi_register_access_port #(
	parameter ADDR_WIDTH = 8,
	parameter DATA_WIDTH = 8
) (
	input wire core_clk,
	input wire reset,
	input wire [DATA_WIDTH-1:0] data_in,
	output reg [DATA_WIDTH-1:0] data_out,
	output reg data_oe,
	output reg dir,
	output reg nxt,
	input wire stp,
	input wire pll_ready,
	input wire async_mode_req,
	output reg sync_mode,
	input wire tx_ready,
	output reg tx_start,
	output reg tx_has_pid,
	output reg [3:0] tx_pid,
	output reg tx_valid,
	output reg [DATA_WIDTH-1:0] tx_byte,
	output reg tx_end,
	output reg reg_wr,
	output reg [ADDR_WIDTH-1:0] reg_wr_addr,
	output reg [DATA_WIDTH-1:0] reg_wr_data
);

	// ****************************************
	// states
	// ****************************************
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_DECODE = 4'h1;
	localparam [3:0] ST_W_CMD = 4'h2;
	localparam [3:0] ST_W_ADDR = 4'h3;
	localparam [3:0] ST_W_DATA = 4'h4;
	localparam [3:0] ST_W_STP = 4'h5;
	localparam [3:0] ST_R_CMD = 4'h6;
	localparam [3:0] ST_R_ADDR = 4'h7;
	localparam [3:0] ST_R_TURN = 4'h8;
	localparam [3:0] ST_R_DRIVE = 4'h9;
	localparam [3:0] ST_T_CMD = 4'ha;
	localparam [3:0] ST_T_DATA = 4'hb;
	localparam [3:0] ST_HOLD = 4'hc;
	localparam [3:0] ST_ASYNC = 4'hd;

	localparam REG_DEPTH = 1 << ADDR_WIDTH;

	// ****************************************
	// storage
	// ****************************************
	reg [DATA_WIDTH-1:0] reg_array [0:REG_DEPTH-1];
	reg [3:0] state;
	reg [DATA_WIDTH-1:0] cmd;
	reg [ADDR_WIDTH-1:0] addr;
	reg [DATA_WIDTH-1:0] wdata;
	reg dir_prev;
	reg pll_meta;
	reg pll_sync;
	wire turn;
	wire bus_ours;
	wire [1:0] cmd_type;
	wire cmd_ext;
	wire [ADDR_WIDTH-1:0] cmd_addr;

	// ****************************************
	// command decode helpers
	// ****************************************

	// one cycle after any change of dir the bus is not read
	assign turn = dir_prev != dir; // see R3
	// the link owns the bus only with dir low and no turn-around
	assign bus_ours = !dir && !turn; // see R24
	// type field of the captured command
	assign cmd_type = cmd[`CMD_TYPE_HI:`CMD_TYPE_LO]; // see R6
	// extended access when the low six bits hold the escape code
	assign cmd_ext = cmd[`CMD_ADDR_HI:`CMD_ADDR_LO] == `EXT_ADDR_CODE; // see R9
	// immediate address is the low six bits, zero extended
	assign cmd_addr = {{(ADDR_WIDTH-6){1'b0}}, cmd[`CMD_ADDR_HI:`CMD_ADDR_LO]}; // see R8

	// ****************************************
	// pll ready synchroniser
	// ****************************************

	// analog ready level passes two flip-flops
	always @(posedge core_clk) begin
		if (reset) begin
			pll_meta <= 1'b0;
			pll_sync <= 1'b0;
		end else begin
			pll_meta <= pll_ready;
			pll_sync <= pll_meta;
		end
	end

	// ****************************************
	// turn-around tracking
	// ****************************************

	// last cycle's dir, to spot the turn-around cycle
	always @(posedge core_clk) begin
		if (reset) begin
			dir_prev <= 1'b1;
		end else begin
			dir_prev <= dir;
		end
	end

	// ****************************************
	// register array write port
	// ****************************************

	// array has no reset; contents only change on a completed write
	always @(posedge core_clk) begin
		if (!reset && state == ST_W_STP && stp) begin
			reg_array[addr] <= wdata; // see R13 see R10
		end
	end

	// ****************************************
	// main protocol sequencer
	// ****************************************

	// every transfer is launched and sampled on the rising edge
	always @(posedge core_clk) begin // see R1
		if (reset) begin
			state <= ST_HOLD;
			cmd <= `DATA_RESET;
			addr <= {ADDR_WIDTH{1'b0}};
			wdata <= `DATA_RESET;
			data_out <= `DATA_RESET;
			data_oe <= 1'b0;
			dir <= 1'b1;
			nxt <= 1'b0;
			sync_mode <= 1'b1;
			tx_start <= 1'b0;
			tx_has_pid <= 1'b0;
			tx_pid <= `PID_RESET;
			tx_valid <= 1'b0;
			tx_byte <= `DATA_RESET;
			tx_end <= 1'b0;
			reg_wr <= 1'b0;
			reg_wr_addr <= {ADDR_WIDTH{1'b0}};
			reg_wr_data <= `DATA_RESET;
		end else begin
			// pulses last one cycle
			tx_start <= 1'b0;
			tx_valid <= 1'b0;
			tx_end <= 1'b0;
			reg_wr <= 1'b0;
			case (state)
				ST_IDLE: begin
					nxt <= 1'b0; // see R23
					if (!pll_sync) begin
						dir <= 1'b1; // see R22
						state <= ST_HOLD;
					end else if (async_mode_req) begin
						dir <= 1'b1; // see R11
						sync_mode <= 1'b0; // see R11
						state <= ST_ASYNC;
					end else if (bus_ours && data_in != `IDLE_BYTE) begin
						cmd <= data_in; // see R24 see R5
						state <= ST_DECODE;
					end
				end
				ST_DECODE: begin
					nxt <= 1'b1; // see R12 see R4
					case (cmd_type)
						`CMD_REG_WRITE: begin
							state <= ST_W_CMD;
						end
						`CMD_REG_READ: begin
							state <= ST_R_CMD;
						end
						`CMD_TRANSMIT: begin
							state <= ST_T_CMD;
						end
						default: begin
							nxt <= 1'b0;
							state <= ST_IDLE;
						end
					endcase
				end
				ST_W_CMD: begin
					// command accepted; dir stays low for the write
					if (cmd_ext) begin
						state <= ST_W_ADDR; // see R16
					end else begin
						addr <= cmd_addr; // see R8
						state <= ST_W_DATA;
					end
				end
				ST_W_ADDR: begin
					addr <= data_in[ADDR_WIDTH-1:0]; // see R9 see R16
					state <= ST_W_DATA;
				end
				ST_W_DATA: begin
					wdata <= data_in; // see R12 see R16
					nxt <= 1'b0; // see R12 see R16
					state <= ST_W_STP;
				end
				ST_W_STP: begin
					// dir never rises during a write
					if (stp) begin // see R14
						reg_wr <= 1'b1; // see R13
						reg_wr_addr <= addr;
						reg_wr_data <= wdata;
						state <= ST_IDLE;
					end
				end
				ST_R_CMD: begin
					if (cmd_ext) begin
						state <= ST_R_ADDR; // see R19
					end else begin
						addr <= cmd_addr;
						nxt <= 1'b0; // see R17
						dir <= 1'b1; // see R17
						state <= ST_R_TURN;
					end
				end
				ST_R_ADDR: begin
					addr <= data_in[ADDR_WIDTH-1:0]; // see R19
					nxt <= 1'b0; // see R19
					dir <= 1'b1; // see R19
					state <= ST_R_TURN;
				end
				ST_R_TURN: begin
					// bus was idle for the turn-around, now drive
					data_out <= reg_array[addr]; // see R18 see R2
					data_oe <= 1'b1; // see R3
					state <= ST_R_DRIVE;
				end
				ST_R_DRIVE: begin
					// link samples now; hand the bus back
					data_oe <= 1'b0; // see R18 see R2
					dir <= 1'b0; // see R18 see R19
					data_out <= `DATA_RESET;
					state <= ST_IDLE;
				end
				ST_T_CMD: begin
					// command byte accepted; report the packet kind
					tx_start <= 1'b1;
					tx_has_pid <= cmd[5:4] == `PID_FLAG_BITS && // see R7
						cmd[`CMD_PID_HI:`CMD_PID_LO] != `PID_RESET;
					tx_pid <= cmd[`CMD_PID_HI:`CMD_PID_LO]; // see R7
					nxt <= tx_ready; // see R4
					state <= ST_T_DATA;
				end
				ST_T_DATA: begin
					if (stp) begin
						// previous byte was the last one
						tx_end <= 1'b1;
						nxt <= 1'b0;
						state <= ST_IDLE;
					end else begin
						if (nxt) begin
							tx_byte <= data_in; // see R4
							tx_valid <= 1'b1;
						end
						nxt <= tx_ready; // see R4
					end
				end
				ST_HOLD: begin
					// interface not ready: keep the bus
					nxt <= 1'b0;
					if (pll_sync) begin
						dir <= 1'b0; // see R22
						state <= ST_IDLE;
					end
				end
				ST_ASYNC: begin
					// pins reassigned, array untouched
					nxt <= 1'b0; // see R10
					if (!async_mode_req) begin
						dir <= 1'b0;
						sync_mode <= 1'b1; // see R11
						state <= ST_IDLE;
					end
				end
				default: begin
					nxt <= 1'b0;
					dir <= 1'b1;
					data_oe <= 1'b0;
					state <= ST_HOLD;
				end
			endcase
		end
	end

endmodule // ulpi_register_access_port

// ### inc/ulpi_port_consts.vh
// constants for the ulpi register access port
//
// Overview of operation
// R1 - all transfers on rising core clock edge
// R2 - device drives data only while dir high
// R3 - no driving, no reading in turn-around cycle
// R4 - nxt throttles link to device bytes
// R5 - link waits dir low, then sends command
// R6 - command type taken from bits seven and six
// R7 - transmit low bits carry optional packet identifier
// R8 - immediate access address is low six bits
// R9 - low bits 2Fh mean extended address follows
// R10 - registers kept through asynchronous modes
// R11 - asynchronous modes stop clock, reassign pins
// R12 - immediate write: nxt T2, data T4 (code samples data at T3)
// R13 - write latched when stp seen at T5 (code sees stp at T4 for an immediate write)
// R14 - dir stays low during register write
// R15 - link returns bus to idle after write
// R16 - extended write: address T3, data T4, nxt drop
// R17 - immediate read: dir up, nxt down at T3
// R18 - immediate read: data T4, dir down T5
// R19 - extended read: dir T4, data T5, release T6
// R20 - link pulses stp one cycle at stream end
// R21 - link presents next byte after nxt
// R22 - dir held high while interface not ready
// R23 - idle byte on bus causes no action
// R24 - no command decode while dir high or turning
`ifndef ULPI_PORT_CONSTS_VH
`define ULPI_PORT_CONSTS_VH

// command byte fields
`define CMD_TYPE_HI 7
`define CMD_TYPE_LO 6
`define CMD_ADDR_HI 5
`define CMD_ADDR_LO 0
`define CMD_PID_HI 3
`define CMD_PID_LO 0

// command types in bits seven and six
`define CMD_IDLE 2'h0
`define CMD_TRANSMIT 2'h1
`define CMD_REG_WRITE 2'h2
`define CMD_REG_READ 2'h3

// special command values
`define IDLE_BYTE 8'h00
`define EXT_ADDR_CODE 6'h2f
`define PID_FLAG_BITS 2'h0

// reset values
`define DATA_RESET 8'h00
`define PID_RESET 4'h0

`endif

// ### sim/ulpi_port_props.sv
// assertion checker for the ulpi register port pins
`timescale 1ns/1ps
module ulpi_port_props (
	input wire core_clk,
	input wire reset,
	input wire [7:0] data_in,
	input wire data_oe,
	input wire dir,
	input wire nxt,
	input wire stp,
	input wire tx_ready,
	input wire reg_wr
);
	// ********
	// port timing
	// ********
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// link owns a quiet bus
	sequence s_idle;
		!dir && data_in == 8'h00 && !nxt && !stp && tx_ready;
	endsequence
	// read command taken, bus turned towards the device
	sequence s_imm_rd;
		$rose(nxt) ##1 (dir && !nxt);
	endsequence
	sequence s_ext_rd;
		$rose(nxt) ##1 nxt ##1 (dir && !nxt);
	endsequence
	// one data cycle, then the bus handed back
	sequence s_give_back;
		data_oe ##1 (!dir && !data_oe);
	endsequence
	a_oe_with_dir: assert property (data_oe |-> dir)
		else $error("data driven with dir low");
	a_turn_quiet: assert property ($changed(dir) |-> !data_oe)
		else $error("data driven in turn cycle");
	a_turn_no_cmd: assert property ($fell(dir) |-> !nxt [*3])
		else $error("nxt during turn");
	a_idle_quiet: assert property (s_idle [*3] |=> !nxt)
		else $error("nxt on idle bus");
	a_nxt_owner: assert property ($rose(nxt) |-> !dir && !$past(dir))
		else $error("nxt while device owns bus");
	a_imm_read: assert property (s_imm_rd |=> s_give_back)
		else $error("short read timing wrong");
	a_ext_read: assert property (s_ext_rd |=> s_give_back)
		else $error("long read timing wrong");
	a_wr_on_stp: assert property (reg_wr |-> $past(stp) && !$past(reg_wr))
		else $error("write without stp");
	a_wr_dir_low: assert property (reg_wr |-> !dir && !$past(dir, 2) && !$past(dir, 4))
		else $error("dir high during write");
	a_stp_ends_tx: assert property (nxt && stp && !dir |=> !nxt)
		else $error("nxt after stp");
endmodule // ulpi_port_props

bind ulpi_register_access_port ulpi_port_props i_props (.core_clk(core_clk), .reset(reset),
	.data_in(data_in), .data_oe(data_oe), .dir(dir), .nxt(nxt), .stp(stp),
	.tx_ready(tx_ready), .reg_wr(reg_wr));

// ### sim/ulpi_link_model.sv
// link controller model facing the ulpi register port
`timescale 1ns/1ps
module ulpi_link_model (
	input wire core_clk,
	input wire dir,
	input wire nxt,
	input wire data_oe,
	input wire [7:0] data_out,
	output wire [7:0] data_in,
	output reg stp
);
	reg [7:0] link_d = 8'h00;
	reg [7:0] last = 8'h00;
	reg own = 1'b1;
	reg dir_q = 1'b1;
	wire link_en;
	// stp rests low between streams, before the first one too
	initial stp = 1'b0;
	// link drives only after a full turn cycle with dir low
	assign link_en = own && !dir && !dir_q;
	// undriven wire shows a moving pattern, not the last value
	assign data_in = data_oe ? data_out : (link_en ? link_d : ~last);
	// remember dir and wire level
	always @(posedge core_clk) begin
		last <= data_in;
		dir_q <= dir;
	end
	// send n bytes, each held until nxt takes it; a read then collects one byte
	task xfer(input [23:0] b, input integer n, input rd_, output [7:0] q);
		integer i;
		begin
			i = 0;
			q = 8'h00;
			while (!link_en) @(posedge core_clk);
			link_d <= b[7:0];
			while (i < n) begin
				@(posedge core_clk);
				if (nxt) begin
					i = i + 1;
					link_d <= (i < n) ? b[8*i +: 8] : 8'h00;
				end
			end
			if (rd_) begin
				own <= 1'b0;
				@(posedge core_clk);
				while (!(dir && dir_q)) @(posedge core_clk);
				q = data_in;
				own <= 1'b1;
			end else begin
				stp <= 1'b1;
				@(posedge core_clk);
				stp <= 1'b0;
			end
		end
	endtask
endmodule // ulpi_link_model

// ### sim/tb.sv
// testbench for the ulpi register access port
`timescale 1ns/1ps
module tb;
	reg core_clk = 1'b0;
	reg reset = 1'b1;
	reg pll_ready = 1'b1;
	reg async_mode_req = 1'b0;
	reg tx_ready = 1'b1;
	wire [7:0] data_in, data_out, reg_wr_addr, reg_wr_data;
	wire [3:0] tx_pid;
	wire [7:0] tx_byte;
	wire data_oe, dir, nxt, stp, sync_mode, tx_has_pid;
	wire tx_start, tx_valid, tx_end, reg_wr;
	integer error_cnt = 0;
	integer n_tests = 0;
	integer mem [0:255];
	integer k;
	reg [31:0] seed = 32'h0000_d556;
	reg [7:0] a, d, q;
	integer n_wr = 0;
	integer n_start = 0;
	integer n_byte = 0;
	integer n_end = 0;
	integer nw = 0;
	reg [7:0] last_byte = 8'h00;
	reg [31:0] rnd = 32'h0000_d556;
	ulpi_register_access_port i_ulpi_register_access_port (.core_clk(core_clk), .reset(reset),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .dir(dir), .nxt(nxt),
		.stp(stp), .pll_ready(pll_ready), .async_mode_req(async_mode_req),
		.sync_mode(sync_mode), .tx_ready(tx_ready), .tx_start(tx_start),
		.tx_has_pid(tx_has_pid), .tx_pid(tx_pid), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_end(tx_end), .reg_wr(reg_wr),
		.reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
	ulpi_link_model i_link (.core_clk(core_clk), .dir(dir), .nxt(nxt), .data_oe(data_oe),
		.data_out(data_out), .data_in(data_in), .stp(stp));
	// count the one-cycle pulses and keep the last accepted packet byte
	always @(posedge core_clk) begin
		if (reg_wr === 1'b1) n_wr <= n_wr + 1;
		if (tx_start === 1'b1) n_start <= n_start + 1;
		if (tx_end === 1'b1) n_end <= n_end + 1;
		if (tx_valid === 1'b1) begin
			n_byte <= n_byte + 1;
			last_byte <= tx_byte;
		end
	end
	// throttle the transmit path at random so nxt has to hold the link
	always @(posedge core_clk) begin
		rnd <= xs(rnd);
		tx_ready <= rnd[3] | rnd[9];
	end
	// ********
	// helpers
	// ********
	initial forever #20 core_clk = ~core_clk;
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// short form where the address fits the command byte, extended form otherwise
	task wr;
		begin
			if (a < 8'h40 && a != 8'h2f) i_link.xfer({8'h00, d, 2'b10, a[5:0]}, 2, 1'b0, q);
			else i_link.xfer({d, a, 8'haf}, 3, 1'b0, q);
			mem[a] = d;
			nw = nw + 1;
			repeat (2) @(posedge core_clk);
			chk(n_wr[7:0], nw[7:0]);
			chk(reg_wr_addr, a);
			chk(reg_wr_data, d);
		end
	endtask
	task rd;
		begin
			if (a < 8'h40 && a != 8'h2f) i_link.xfer({16'h0000, 2'b11, a[5:0]}, 1, 1'b1, q);
			else i_link.xfer({8'h00, a, 8'hef}, 2, 1'b1, q);
			chk(q, mem[a][7:0]);
		end
	endtask
	task print_verdict;
		begin
			$display("tests=%0d errors=%0d", n_tests, error_cnt);
			if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		#400000;
		error_cnt = error_cnt + 1;
		print_verdict;
	end
	// main sequence
	initial begin
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		chk({5'h00, data_oe, sync_mode, dir}, 8'h03);
		for (k = 0; k < 12; k = k + 1) begin
			seed = xs(seed);
			a = (k == 0) ? 8'h2f : ((k == 1) ? 8'h3f : seed[7:0]);
			d = seed[15:8];
			wr;
			rd;
		end
		i_link.xfer(24'h33_5a45, 3, 1'b0, q);
		repeat (2) @(posedge core_clk);
		chk({3'b000, tx_has_pid, tx_pid}, 8'h15);
		chk({n_start[3:0], n_end[3:0]}, 8'h11);
		chk(n_byte[7:0], 8'h02);
		chk(last_byte, 8'h33);
		i_link.xfer(24'h00_7740, 2, 1'b0, q);
		repeat (2) @(posedge core_clk);
		chk({3'b000, tx_has_pid, tx_pid}, 8'h00);
		chk({n_start[3:0], n_end[3:0]}, 8'h22);
		chk(n_byte[7:0], 8'h03);
		chk(last_byte, 8'h77);
		pll_ready <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk({7'h00, dir}, 8'h01);
		pll_ready <= 1'b1;
		async_mode_req <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk({6'h00, sync_mode, dir}, 8'h01);
		async_mode_req <= 1'b0;
		repeat (8) @(posedge core_clk);
		chk({6'h00, sync_mode, dir}, 8'h02);
		a = 8'h3f;
		rd;
		print_verdict;
	end
endmodule // tb
